// ==== design/rtcc_params.svh ====
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

// ****************************************
// Map
// ****************************************
`define RTCC_AW         7
`define RTCC_CLK_FIRST  7'h00
`define RTCC_CLK_LAST   7'h1F
`define RTCC_RAM_FIRST  7'h20
`define RTCC_RAM_LAST   7'h7F
`define RTCC_RAM_BYTES  96
`define RTCC_TIME_REGS  7
`define RTCC_A_SEC      3'h0
`define RTCC_A_MIN      3'h1
`define RTCC_A_HOUR     3'h2
`define RTCC_A_DAY      3'h3
`define RTCC_A_DATE     3'h4
`define RTCC_A_MON      3'h5
`define RTCC_A_YEAR     3'h6
`define RTCC_WR_BIT     7

// ****************************************
// Fields
// ****************************************
`define RTCC_MODE_BIT   6
`define RTCC_MER_BIT    5
`define RTCC_CENT_BIT   7
`define RTCC_M_SEC      8'h7F
`define RTCC_M_HOUR     8'h7F
`define RTCC_M_DAY      8'h07
`define RTCC_M_DATE     8'h3F
`define RTCC_M_MON      8'h9F
`define RTCC_M_YEAR     8'hFF

// ****************************************
// Reset values and counts
// ****************************************
`define RTCC_RST_ZERO   8'h00
`define RTCC_RST_ONE    8'h01
`define RTCC_DAY_LAST   8'h07
`define RTCC_OSC_HZ     32768
`define RTCC_OSC_DIV    32768
`define RTCC_BYTE_MID   3'h3
`define RTCC_BYTE_END   3'h7
`endif

// ==== design/rtcc_pkg.sv ====
`include "rtcc_params.svh"
package rtcc_pkg;
  typedef logic [7:0] rtcc_byte_t;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
  } rtcc_sync_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] cnt;
    logic [6:0] shin;
    rtcc_byte_t word;
    logic       ready;
    logic       have_addr;
    logic       rd;
    rtcc_byte_t sho;
    logic       oe;
  } rtcc_link_s;

  typedef struct packed {
    rtcc_byte_t [`RTCC_TIME_REGS-1:0] tm;
    rtcc_byte_t [`RTCC_TIME_REGS-1:0] snap;
    rtcc_byte_t [`RTCC_RAM_BYTES-1:0] ram;
    logic [`RTCC_AW-1:0]              ptr;
    logic                             have_addr;
    logic                             wr;
    logic [14:0]                      div;
    logic                             ce_q;
    logic                             osc_q;
    logic                             rdy_q;
    logic                             bat_q;
    logic                             sealed;
    logic                             on_backup;
    logic                             pf_n;
    rtcc_byte_t                       rd_word;
  } rtcc_core_s;
endpackage

// ==== design/rtcc_sync.sv ====
`timescale 1ns/1ps
module rtcc_sync
  import rtcc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [6:0] pin_in,
  output logic [6:0]      pin_sync
);
  rtcc_sync_s s;
  rtcc_sync_s next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pin_sync = s.s2;
endmodule

// ==== design/rtcc_link.sv ====
`timescale 1ns/1ps
module rtcc_link
  import rtcc_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       reset_n,
  input  wire logic       chip_select,
  input  wire logic       serial_in_line,
  input  wire logic       link_mode_select,
  input  wire logic [7:0] rd_word,
  output logic [7:0]      byte_word,
  output logic            byte_ready,
  output logic            serial_out_line,
  output logic            serial_out_oe
);
  rtcc_link_s s;
  rtcc_link_s next_s;
  logic       frame_rst_n;

  // Frame logic is cleared whenever select drops
  assign frame_rst_n = reset_n & chip_select;

  always_comb
  begin
    next_s         = s;
    next_s.mode    = {s.mode[0], link_mode_select};
    next_s.cnt     = s.cnt + 3'h1;
    next_s.shin    = {s.shin[5:0], serial_in_line};
    next_s.sho     = {s.sho[6:0], 1'b0};
    if (s.cnt == `RTCC_BYTE_MID)
      next_s.ready = 1'b0;
    if (s.cnt == `RTCC_BYTE_END)
    begin
      next_s.word  = {s.shin, serial_in_line};
      next_s.ready = 1'b1;
      next_s.sho   = rd_word;
      if (!s.have_addr)
      begin
        next_s.have_addr = 1'b1;
        next_s.rd        = !s.shin[6];
      end
    end
    // SPI drives its own pin from the third link clock of a frame on, 3-wire only in read data
    next_s.oe = s.mode[1] |
                (next_s.have_addr & next_s.rd);
  end

  always_ff @(posedge link_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign byte_word       = s.word;
  assign byte_ready      = s.ready;
  assign serial_out_line = s.sho[7];
  assign serial_out_oe   = s.oe;
endmodule

// ==== design/rtcc_core.sv ====
`timescale 1ns/1ps
`include "rtcc_params.svh"
module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int OSC_DIV = `RTCC_OSC_DIV
)
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic link_clk,
  input  wire logic chip_select,
  input  wire logic serial_in_line,
  input  wire logic link_mode_select,
  input  wire logic osc_clk,
  input  wire logic main_above_threshold,
  input  wire logic main_above_backup,
  input  wire logic backup_attached,
  input  wire logic osc_enable,
  output logic      serial_out_line,
  output logic      serial_out_oe,
  output logic      on_backup,
  output logic      power_fail_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic rtcc_byte_t bcd_inc(input rtcc_byte_t v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic rtcc_byte_t month_last(input rtcc_byte_t mon,
                                            input rtcc_byte_t yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    unique case (mon[4:0])
      5'h02:   month_last = leap ? 8'h29 : 8'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  function automatic logic [`RTCC_AW-1:0] ptr_next(
    input logic [`RTCC_AW-1:0] p);
    if (p == `RTCC_CLK_LAST)
      ptr_next = `RTCC_CLK_FIRST;
    else if (p == `RTCC_RAM_LAST)
      ptr_next = `RTCC_RAM_FIRST;
    else
      ptr_next = p + 7'h01;
  endfunction

  function automatic rtcc_byte_t wmask(input logic [2:0] a);
    unique case (a)
      `RTCC_A_SEC,
      `RTCC_A_MIN:  wmask = `RTCC_M_SEC;
      `RTCC_A_HOUR: wmask = `RTCC_M_HOUR;
      `RTCC_A_DAY:  wmask = `RTCC_M_DAY;
      `RTCC_A_DATE: wmask = `RTCC_M_DATE;
      `RTCC_A_MON:  wmask = `RTCC_M_MON;
      default:      wmask = `RTCC_M_YEAR;
    endcase
  endfunction

  // ****************************************
  // Synchronisers and link
  // ****************************************
  rtcc_core_s s;
  rtcc_core_s next_s;
  logic [6:0] sy;
  logic       sy_ce;
  logic       sy_osc;
  logic       sy_rdy;
  logic       sy_pf;
  logic       sy_bk;
  logic       sy_bat;
  logic       sy_oen;
  rtcc_byte_t byte_word;
  logic       byte_ready;

  rtcc_sync u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pin_in   ({osc_enable, backup_attached, main_above_backup,
                main_above_threshold, byte_ready, osc_clk,
                chip_select}),
    .pin_sync (sy)
  );

  assign sy_ce  = sy[0];
  assign sy_osc = sy[1];
  assign sy_rdy = sy[2];
  assign sy_pf  = sy[3];
  assign sy_bk  = sy[4];
  assign sy_bat = sy[5];
  assign sy_oen = sy[6];

  rtcc_link u_link (
    .link_clk         (link_clk),
    .reset_n          (reset_n),
    .chip_select      (chip_select),
    .serial_in_line   (serial_in_line),
    .link_mode_select (link_mode_select),
    .rd_word          (s.rd_word),
    .byte_word        (byte_word),
    .byte_ready       (byte_ready),
    .serial_out_line  (serial_out_line),
    .serial_out_oe    (serial_out_oe)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic       ce_rise;
  logic       osc_rise;
  logic       ev;
  logic       cnt_en;
  logic       tick;
  logic       c_min;
  logic       c_hr;
  logic       c_day;
  logic       c_mon;
  logic       c_yr;
  logic       wrap;
  rtcc_byte_t h_inc;
  rtcc_byte_t m_last;

  assign ce_rise  = sy_ce & !s.ce_q;
  assign osc_rise = sy_osc & !s.osc_q;
  assign ev       = sy_rdy & !s.rdy_q;
  assign cnt_en   = sy_oen & (sy_pf | sy_bk | s.on_backup);
  assign tick     = osc_rise && cnt_en &&
                    s.div == 15'(OSC_DIV - 1);
  assign h_inc    = bcd_inc(s.tm[`RTCC_A_HOUR]);
  assign m_last   = month_last(s.tm[`RTCC_A_MON], s.tm[`RTCC_A_YEAR]);
  assign wrap     = ev && s.have_addr && s.ptr == `RTCC_CLK_LAST;

  always_comb
  begin
    next_s       = s;
    next_s.ce_q  = sy_ce;
    next_s.osc_q = sy_osc;
    next_s.rdy_q = sy_rdy;
    next_s.bat_q = sy_bat;
    next_s.pf_n  = sy_pf;
    c_min        = tick && s.tm[`RTCC_A_SEC] == 8'h59;
    c_hr         = c_min && s.tm[`RTCC_A_MIN] == 8'h59;
    c_day        = 1'b0;

    // Oscillator divider
    if (osc_rise && cnt_en)
      next_s.div = tick ? 15'h0 : s.div + 15'h1;

    // Seconds and minutes
    if (tick)
      next_s.tm[`RTCC_A_SEC] = c_min ? `RTCC_RST_ZERO
                                     : bcd_inc(s.tm[`RTCC_A_SEC]);
    if (c_min)
      next_s.tm[`RTCC_A_MIN] = c_hr ? `RTCC_RST_ZERO
                                    : bcd_inc(s.tm[`RTCC_A_MIN]);

    // Hours in either mode
    if (c_hr)
    begin
      if (s.tm[`RTCC_A_HOUR][`RTCC_MODE_BIT])
      begin
        if (s.tm[`RTCC_A_HOUR][4:0] == 5'h12)
          next_s.tm[`RTCC_A_HOUR][4:0] = 5'h01;
        else if (s.tm[`RTCC_A_HOUR][4:0] == 5'h11)
        begin
          next_s.tm[`RTCC_A_HOUR][4:0] = 5'h12;
          next_s.tm[`RTCC_A_HOUR][`RTCC_MER_BIT] =
            !s.tm[`RTCC_A_HOUR][`RTCC_MER_BIT];
          c_day = s.tm[`RTCC_A_HOUR][`RTCC_MER_BIT];
        end
        else
          next_s.tm[`RTCC_A_HOUR][4:0] = h_inc[4:0];
      end
      else if (s.tm[`RTCC_A_HOUR][5:0] == 6'h23)
      begin
        next_s.tm[`RTCC_A_HOUR][5:0] = 6'h00;
        c_day = 1'b1;
      end
      else
        next_s.tm[`RTCC_A_HOUR][5:0] = h_inc[5:0];
    end

    // Day of week, date, month, year
    c_mon = c_day && s.tm[`RTCC_A_DATE] == m_last;
    c_yr  = c_mon && s.tm[`RTCC_A_MON][4:0] == 5'h12;
    if (c_day)
    begin
      next_s.tm[`RTCC_A_DAY] =
        (s.tm[`RTCC_A_DAY] == `RTCC_DAY_LAST) ? `RTCC_RST_ONE
                                              : bcd_inc(s.tm[`RTCC_A_DAY]);
      next_s.tm[`RTCC_A_DATE] = c_mon ? `RTCC_RST_ONE
                                      : bcd_inc(s.tm[`RTCC_A_DATE]);
    end
    if (c_mon)
      next_s.tm[`RTCC_A_MON][4:0] =
        c_yr ? 5'h01 : 5'(bcd_inc({3'h0, s.tm[`RTCC_A_MON][4:0]}));
    if (c_yr)
    begin
      next_s.tm[`RTCC_A_YEAR] =
        (s.tm[`RTCC_A_YEAR] == 8'h99) ? `RTCC_RST_ZERO
                                      : bcd_inc(s.tm[`RTCC_A_YEAR]);
      if (s.tm[`RTCC_A_YEAR] == 8'h99)
        next_s.tm[`RTCC_A_MON][`RTCC_CENT_BIT] =
          !s.tm[`RTCC_A_MON][`RTCC_CENT_BIT];
    end

    // Host bytes from the link
    if (ce_rise)
    begin
      next_s.have_addr = 1'b0;
      next_s.snap      = s.tm;
    end
    else if (ev && !s.have_addr)
    begin
      next_s.have_addr = 1'b1;
      next_s.ptr       = byte_word[`RTCC_AW-1:0];
      next_s.wr        = byte_word[`RTCC_WR_BIT];
    end
    else if (ev)
    begin
      if (s.wr && sy_pf && s.ptr < 7'(`RTCC_TIME_REGS))
        next_s.tm[s.ptr[2:0]] = byte_word & wmask(s.ptr[2:0]);
      if (s.wr && sy_pf && s.ptr >= `RTCC_RAM_FIRST)
        next_s.ram[s.ptr - `RTCC_RAM_FIRST] = byte_word;
      next_s.ptr = ptr_next(s.ptr);
      if (wrap)
        next_s.snap = s.tm;
    end

    // Read byte for the next slot, refused while power is low
    if (!s.pf_n)
      next_s.rd_word = `RTCC_RST_ZERO;
    else if (s.ptr < 7'(`RTCC_TIME_REGS))
      next_s.rd_word = s.snap[s.ptr[2:0]];
    else if (s.ptr >= `RTCC_RAM_FIRST)
      next_s.rd_word = s.ram[s.ptr - `RTCC_RAM_FIRST];
    else
      next_s.rd_word = `RTCC_RST_ZERO;

    // Power switching and freshness seal
    if (sy_pf)
      next_s.sealed = 1'b0;
    if (sy_bat && !s.bat_q)
      next_s.sealed = 1'b1;
    next_s.on_backup = !next_s.sealed && !sy_pf && !sy_bk;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s                   <= '0;
      s.tm[`RTCC_A_DAY]   <= `RTCC_RST_ONE;
      s.tm[`RTCC_A_DATE]  <= `RTCC_RST_ONE;
      s.tm[`RTCC_A_MON]   <= `RTCC_RST_ONE;
      s.snap[`RTCC_A_DAY] <= `RTCC_RST_ONE;
      s.snap[`RTCC_A_DATE] <= `RTCC_RST_ONE;
      s.snap[`RTCC_A_MON] <= `RTCC_RST_ONE;
      s.sealed            <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign on_backup    = s.on_backup;
  assign power_fail_n = s.pf_n;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  clk_wrap_a: assert property (wrap |=> s.ptr == 7'h00)
    else $error("clock pointer did not wrap to 00h");
  ram_wrap_a: assert property (ev && s.have_addr && !ce_rise &&
                               s.ptr == 7'h7F |=> s.ptr == 7'h20)
    else $error("RAM pointer did not wrap to 20h");
  snap_ce_a: assert property (ce_rise |=> s.snap == $past(s.tm))
    else $error("snapshot not taken on select rise");
  read_snap_a: assert property (s.pf_n && s.ptr == 7'h00 |=>
                                s.rd_word == $past(s.snap[0]))
    else $error("read did not come from snapshot");
  day_roll_a: assert property (c_day && s.tm[3] == 8'h07 |=>
                               s.tm[3] == 8'h01)
    else $error("day of week did not roll to 1");
  feb_end_a: assert property (c_day && s.tm[5][4:0] == 5'h02 &&
                              s.tm[6] == 8'h99 && s.tm[4] == 8'h28 |=>
                              s.tm[4] == 8'h01)
    else $error("February did not end at 28");
  noon_a: assert property (c_hr && s.tm[2] == 8'h51 |=>
                           s.tm[2] == 8'h72)
    else $error("12-hour mode missed noon");
  century_a: assert property (c_yr && s.tm[6] == 8'h99 |=>
                              s.tm[5][7] != $past(s.tm[5][7]))
    else $error("century bit not toggled");
  refuse_a: assert property (!s.pf_n |=> s.rd_word == 8'h00)
    else $error("read not refused below threshold");
  backup_a: assert property (s.on_backup |->
                             !s.pf_n && !$past(sy_bk))
    else $error("backup used with main supply valid");
  seal_a: assert property (s.sealed |-> !s.on_backup)
    else $error("backup drawn while sealed");
  hold_a: assert property (!cnt_en && !ev |=> $stable(s.tm[0]))
    else $error("time counted without supply or oscillator");
  zero_bit_a: assert property (s.tm[0][7] == 1'b0 &&
                               s.tm[3][7:3] == 5'h00)
    else $error("defined zero bit is set");

  wrap_c: cover property (wrap);
  century_c: cover property (c_yr && s.tm[6] == 8'h99);
  backup_c: cover property (s.on_backup);
  write_c: cover property (ev && s.have_addr && s.wr);
endmodule

// ==== tb/rtcc_host_model.sv ====
`timescale 1ns/1ps
module rtcc_host_model
  import rtcc_pkg::*;
(
  output logic      link_clk,
  output logic      chip_select,
  output logic      serial_in_line,
  input  wire logic serial_out_line,
  input  wire logic serial_out_oe,
  input  wire logic link_mode_select
);
  rtcc_byte_t tx [16];
  rtcc_byte_t rx [16];
  logic [15:0] oe_map;
  logic       host_bit;

  // Shared line in 3-wire mode, separate lines in SPI mode
  assign serial_in_line = (!link_mode_select && serial_out_oe) ?
                          serial_out_line : host_bit;

  initial
  begin
    link_clk = 1'b0;
    chip_select = 1'b0;
    host_bit = 1'b1;
  end

  // ****
  // Frame: header byte, then n byte slots
  // ****
  task automatic frame(input rtcc_byte_t hdr, input int n);
    rtcc_byte_t b;
    begin
      #23 chip_select = 1'b1;
      for (int s = 0; s <= n; s++)
      begin
        b = (s == 0) ? hdr : tx[s-1];
        for (int i = 7; i >= 0; i--)
        begin
          host_bit = b[i];
          #16 rx[s] = {rx[s][6:0], serial_out_line};
          oe_map[s] = serial_out_oe;
          link_clk = 1'b1;
          #16 link_clk = 1'b0;
        end
      end
      #50 chip_select = 1'b0;
      host_bit = ~host_bit;
      #60;
    end
  endtask
endmodule

// ==== tb/rtcc_core_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) \
    begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module rtcc_core_test;
  import rtcc_pkg::*;
  logic ref_clk;
  logic reset_n;
  logic link_clk;
  logic chip_select;
  logic serial_in_line;
  logic link_mode_select;
  logic osc_clk;
  logic main_above_threshold;
  logic main_above_backup;
  logic backup_attached;
  logic osc_enable;
  logic serial_out_line;
  logic serial_out_oe;
  logic on_backup;
  logic power_fail_n;
  int   fails;
  int   compares;
  logic [55:0] wv [7] = '{56'h59592307311299, 56'h59592303280204,
    56'h59592303280299, 56'h59595102300410, 56'h59597102300410,
    56'h58000001010100, 56'h58000001010100};
  logic [55:0] ev [7] = '{56'h00000001018100, 56'h00000004290204,
    56'h00000004010399, 56'h00007202300410, 56'h00005203010510,
    56'h58000001010100, 56'h59000001010100};
  logic [2:0]  cf [7] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h3, 3'h4};

  rtcc_core #(.OSC_DIV(4)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk),
    .chip_select(chip_select), .serial_in_line(serial_in_line),
    .link_mode_select(link_mode_select), .osc_clk(osc_clk),
    .main_above_threshold(main_above_threshold),
    .main_above_backup(main_above_backup),
    .backup_attached(backup_attached), .osc_enable(osc_enable),
    .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
    .on_backup(on_backup), .power_fail_n(power_fail_n));

  rtcc_host_model i_host (
    .link_clk(link_clk), .chip_select(chip_select),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .link_mode_select(link_mode_select));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****
  // Access tasks
  // ****
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic put(input logic [55:0] v, input int n);
    for (int k = 0; k < n; k++)
      i_host.tx[k] = v[55-8*k -: 8];
  endtask

  task automatic wr(input rtcc_byte_t a, input int n);
    i_host.frame({1'b1, a[6:0]}, n);
    `CHK("oe write", link_mode_select, i_host.oe_map[n])
  endtask

  task automatic chk_rd(input rtcc_byte_t a, input int n,
                        input logic [55:0] e);
    i_host.frame({1'b0, a[6:0]}, n + 1);
    `CHK("oe address", link_mode_select, i_host.oe_map[0])
    `CHK("oe read data", 1'b1, i_host.oe_map[n+1])
    for (int k = 0; k < n; k++)
      `CHK("read byte", e[55-8*k -: 8], i_host.rx[k+2])
  endtask

  task automatic osc(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge ref_clk);
      osc_clk <= 1'b1;
      repeat (2) @(posedge ref_clk);
      osc_clk <= 1'b0;
    end
  endtask

  task automatic supply(input logic [2:0] c);
    @(posedge ref_clk);
    osc_enable <= c[2];
    main_above_threshold <= c[1];
    main_above_backup <= c[0];
    repeat (8) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    fails = 0;
    compares = 0;
    reset_n = 1'b0;
    link_mode_select = 1'b0;
    osc_clk = 1'b0;
    main_above_threshold = 1'b1;
    main_above_backup = 1'b1;
    backup_attached = 1'b0;
    osc_enable = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk_rd(8'h00, 7, 56'h00000001010100);
    $display("test reset done");
    for (int c = 0; c < 7; c++)
    begin
      put(wv[c], 7);
      wr(8'h00, 7);
      supply(cf[c]);
      osc(4);
      supply(3'h7);
      chk_rd(8'h00, 7, ev[c]);
    end
    $display("test calendar done");
    put(56'h10000000000000, 1);
    wr(8'h00, 1);
    fork
      chk_rd(8'h1E, 3, 56'h00001100000000);
      begin
        #100;
        osc(4);
      end
    join
    fork
      chk_rd(8'h00, 1, 56'h11000000000000);
      begin
        #100;
        osc(4);
      end
    join
    $display("test snapshot done");
    put(56'hA1A2A300000000, 3);
    wr(8'h7E, 3);
    chk_rd(8'h7F, 2, 56'hA2A30000000000);
    $display("test ram done");
    @(posedge ref_clk);
    backup_attached <= 1'b1;
    supply(3'h4);
    `CHK("on_backup", 1'b0, on_backup)
    `CHK("power_fail_n", 1'b0, power_fail_n)
    put(56'h55000000000000, 1);
    wr(8'h20, 1);
    chk_rd(8'h00, 1, 56'h0);
    supply(3'h6);
    `CHK("power_fail_n", 1'b1, power_fail_n)
    supply(3'h5);
    `CHK("on_backup", 1'b0, on_backup)
    supply(3'h4);
    `CHK("on_backup", 1'b1, on_backup)
    supply(3'h7);
    chk_rd(8'h20, 1, 56'hA3000000000000);
    $display("test power done");
    @(posedge ref_clk);
    link_mode_select <= 1'b1;
    chk_rd(8'h7E, 3, 56'hA1A2A300000000);
    $display("test spi done");
    print_verdict();
  end
endmodule
